// ==== rtl/tvu_pkg.sv ====
// Function
// RULE1 - Every vector address is placed in the code segment held by the vector segment register.
// RULE2 - Adjacent vectors lie apart by the vector spacing field, four bytes by default.
// RULE3 - The eighteen serial channel requests map to trap numbers 0x50 to 0x61, one node each.
// RULE4 - System control request 1 maps to 0x6B, request 0 to 0x6C, flash 0x6D, clock 0x6E, subchannel end 0x6F.
// RULE5 - A hardware trap condition causes an immediate non-maskable branch to its own vector.
// RULE6 - Each hardware trap condition sets its own bit in the trap flag register.
// RULE7 - A hardware trap preempts running code unless a higher priority trap service is active; the code also waits while one of equal priority is in service.
// RULE8 - While a hardware trap is in service, standard interrupts and event controller transfers wait.
// RULE9 - Class A traps vector to 0x08, 0x10, 0x18 and 0x20 with priorities 02, 04, 06 and 08.
// RULE10 - All five class B conditions share vector 0x28 at priority 0x0A and keep separate flags.
// RULE11 - A software trap branches to trap number 0x00 to 0x7F in steps of four and keeps the CPU priority; the code takes any number in that range.
// RULE12 - Software may request an unassigned node by setting its request bit and it is then serviced.
// RULE13 - Reset has the highest precedence with vector offset 0x0000 and priority zero.
package tvu_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int HW_NUM      = 9;
   localparam int CLASS_A_NUM = 4;
   localparam int NODE_NUM    = 32;
   localparam int SERIAL_NUM  = 18;
   localparam int TRAP_W      = 7;
   localparam int PRIO_W      = 4;
   localparam int SEG_W       = 8;
   localparam int OFF_W       = 16;
   localparam int VSC_W       = 2;
   localparam int IST_W       = 3;

   // ----------------------------------------------------------------
   // Register offsets and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_VSEG  = 8'h00;
   localparam logic [7:0] REG_CFG   = 8'h04;
   localparam logic [7:0] REG_TFLAG = 8'h08;
   localparam logic [7:0] REG_NODE  = 8'h0c;
   localparam logic [7:0] REG_SVC   = 8'h10;
   localparam logic [7:0] REG_IST   = 8'h14;
   localparam logic [7:0] REG_IMASK = 8'h18;

   localparam int VSC_LSB       = 0;
   localparam int SVC_BUSY_BIT  = 0;
   localparam int SVC_PRIO_LSB  = 4;
   localparam int SVC_TRAP_LSB  = 8;
   localparam int IST_HW        = 0;
   localparam int IST_SW        = 1;
   localparam int IST_NODE      = 2;
   localparam int VEC_SHIFT_BASE = 2;

   // ----------------------------------------------------------------
   // Trap numbers
   // ----------------------------------------------------------------
   localparam logic [6:0] TRAP_RESET   = 7'h00;
   localparam logic [6:0] TRAP_SR0     = 7'h02;
   localparam logic [6:0] TRAP_STACK_OVERFLOW_FLAG   = 7'h04;
   localparam logic [6:0] TRAP_STACK_UNDERFLOW_FLAG   = 7'h06;
   localparam logic [6:0] TRAP_SBRK    = 7'h08;
   localparam logic [6:0] TRAP_CLASS_B = 7'h0a;
   localparam logic [6:0] NODE_BASE    = 7'h50;
   localparam logic [6:0] SERIAL_LAST  = 7'h61;
   localparam logic [6:0] TRAP_SCU1    = 7'h6b;
   localparam logic [6:0] TRAP_SUBCH   = 7'h6f;
   localparam int UNASSIGNED_NUM = int'(TRAP_SCU1) - int'(SERIAL_LAST) - 1;

   localparam logic [6:0] CLASS_A_TRAPS [CLASS_A_NUM] =
      '{TRAP_SR0, TRAP_STACK_OVERFLOW_FLAG, TRAP_STACK_UNDERFLOW_FLAG, TRAP_SBRK};

   typedef enum logic [1:0] {KIND_RESET, KIND_HW, KIND_SW, KIND_NODE} tvu_kind_type;

   function automatic logic [OFF_W-1:0] vec_offset(input logic [TRAP_W-1:0] trap,
                                                   input logic [VSC_W-1:0]  vsc);
      return OFF_W'(trap) << (VEC_SHIFT_BASE + int'(vsc));
   endfunction

endpackage

// ==== rtl/tvu_sel_if.sv ====
`timescale 1ns/1ps
interface tvu_sel_if;
   logic [tvu_pkg::HW_NUM-1:0] pend;
   logic                       valid;
   logic [tvu_pkg::TRAP_W-1:0] trap;
   logic [tvu_pkg::PRIO_W-1:0] prio;

   modport arb  (input pend, output valid, output trap, output prio);
   modport user (output pend, input valid, input trap, input prio);
endinterface

// ==== rtl/tvu_hw_select.sv ====
`timescale 1ns/1ps
module tvu_hw_select
(
   tvu_sel_if.arb sel
);

   // ----------------------------------------------------------------
   // Hardware trap selection
   // ----------------------------------------------------------------
   // The trap priority equals the low bits of the trap number, so a
   // lower number always wins and class B sits below all of class A.
   always_comb
   begin
      sel.valid = |sel.pend;
      sel.trap  = tvu_pkg::TRAP_CLASS_B;                           // RULE10
      for (int i = tvu_pkg::CLASS_A_NUM - 1; i >= 0; i--)
      begin
         if (sel.pend[i])
         begin
            sel.trap = tvu_pkg::CLASS_A_TRAPS[i];                  // RULE9
         end
      end
      sel.prio = sel.trap[tvu_pkg::PRIO_W-1:0];
   end

endmodule

// ==== rtl/tvu_trap_vector.sv ====
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module tvu_trap_vector
(
   input  wire logic                         clk_i,
   input  wire logic                         rst_i,
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [7:0]                   wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [31:0]                  wb_dat_i,
   output logic      [31:0]                  wb_dat_o,
   output logic                              wb_ack_o,
   output logic                              irq_o,
   input  wire logic [tvu_pkg::HW_NUM-1:0]   hw_cond_i,
   input  wire logic                         sw_trap_i,
   input  wire logic [tvu_pkg::TRAP_W-1:0]   sw_trap_num_i,
   input  wire logic [tvu_pkg::PRIO_W-1:0]   cpu_prio_i,
   input  wire logic                         cpu_int_ready_i,
   input  wire logic                         trap_return_i,
   input  wire logic [tvu_pkg::SERIAL_NUM-1:0] serial_req_i,
   input  wire logic [1:0]                   scu_req_i,
   input  wire logic                         flash_req_i,
   input  wire logic                         rtc_req_i,
   input  wire logic                         subch_end_req_i,
   output logic                              branch_valid_o,
   output logic      [23:0]                  branch_addr_o,
   output logic      [tvu_pkg::TRAP_W-1:0]   branch_trap_o,
   output logic      [tvu_pkg::PRIO_W-1:0]   branch_prio_o,
   output logic      [1:0]                   branch_kind_o,
   output logic                              event_ctrl_enable_o
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic                         ack;
      logic [31:0]                  dat;
      logic [tvu_pkg::SEG_W-1:0]    vseg;
      logic [tvu_pkg::VSC_W-1:0]    vsc;
      logic [tvu_pkg::HW_NUM-1:0]   tflag;
      logic [tvu_pkg::HW_NUM-1:0]   hpend;
      logic [tvu_pkg::NODE_NUM-1:0] npend;
      logic                         swp;
      logic [tvu_pkg::TRAP_W-1:0]   swnum;
      logic                         rst_done;
      logic                         busy;
      logic [tvu_pkg::PRIO_W-1:0]   cprio;
      logic [tvu_pkg::TRAP_W-1:0]   last;
      logic [tvu_pkg::IST_W-1:0]    ists;
      logic [tvu_pkg::IST_W-1:0]    imask;
      logic                         irq;
      logic                         bv;
      logic [23:0]                  baddr;
      logic [tvu_pkg::TRAP_W-1:0]   class_b_vector;
      logic [tvu_pkg::PRIO_W-1:0]   bprio;
      tvu_pkg::tvu_kind_type        bkind;
      logic                         ectl;
   } tvu_state_type;

   tvu_state_type                    state_reg;
   tvu_state_type                    state_next;
   logic [tvu_pkg::NODE_NUM-1:0]     node_req;
   tvu_sel_if                        sel_bus ();

   function automatic logic [31:0] byte_mask(input logic [3:0] sel);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++)
      begin
         m[b*8 +: 8] = {8{sel[b]}};
      end
      return m;
   endfunction

   function automatic logic [4:0] first_node(input logic [tvu_pkg::NODE_NUM-1:0] v);
      logic [4:0] idx;
      idx = '0;
      for (int i = tvu_pkg::NODE_NUM - 1; i >= 0; i--)
      begin
         if (v[i])
         begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction

   // ----------------------------------------------------------------
   // Node request map
   // ----------------------------------------------------------------
   // Unassigned nodes have no hardware source; only software sets them.
   assign node_req = {subch_end_req_i, rtc_req_i, flash_req_i,             // RULE4
                      scu_req_i[0], scu_req_i[1],                          // RULE4
                      {tvu_pkg::UNASSIGNED_NUM{1'b0}},
                      serial_req_i};                                       // RULE3

   assign sel_bus.pend = state_reg.hpend | hw_cond_i;

   tvu_hw_select u_sel
   (
      .sel (sel_bus)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic                         acc;
      logic [31:0]                  wm;
      logic [31:0]                  rd;
      logic [tvu_pkg::HW_NUM-1:0]   hclr;
      logic [tvu_pkg::NODE_NUM-1:0] nclr;
      logic [tvu_pkg::NODE_NUM-1:0] nset;
      logic [4:0]                   nidx;
      logic                         hw_ok;
      logic [tvu_pkg::TRAP_W-1:0]   tnum;

      state_next = state_reg;
      acc        = wb_cyc_i && wb_stb_i && state_reg.ack;
      wm         = byte_mask(wb_sel_i);
      rd         = '0;
      hclr       = '0;
      nclr       = '0;
      nset       = '0;
      nidx       = first_node(state_reg.npend);
      tnum       = '0;
      hw_ok      = 1'b0;

      // Registered ack: the access completes at the edge where ack is seen.
      state_next.ack = wb_cyc_i && wb_stb_i && !state_reg.ack;
      case ({wb_adr_i[7:2], 2'b00})
         tvu_pkg::REG_VSEG:  rd[tvu_pkg::SEG_W-1:0] = state_reg.vseg;
         tvu_pkg::REG_CFG:   rd[tvu_pkg::VSC_LSB +: tvu_pkg::VSC_W] = state_reg.vsc;
         tvu_pkg::REG_TFLAG: rd[tvu_pkg::HW_NUM-1:0] = state_reg.tflag;
         tvu_pkg::REG_NODE:  rd = state_reg.npend;
         tvu_pkg::REG_SVC:
         begin
            rd[tvu_pkg::SVC_BUSY_BIT]                   = state_reg.busy;
            rd[tvu_pkg::SVC_PRIO_LSB +: tvu_pkg::PRIO_W] = state_reg.cprio;
            rd[tvu_pkg::SVC_TRAP_LSB +: tvu_pkg::TRAP_W] = state_reg.last;
         end
         tvu_pkg::REG_IST:   rd[tvu_pkg::IST_W-1:0] = state_reg.ists;
         tvu_pkg::REG_IMASK: rd[tvu_pkg::IST_W-1:0] = state_reg.imask;
         default:            rd = '0;
      endcase
      state_next.dat = state_next.ack ? rd : '0;

      if (acc && wb_we_i)
      begin
         case ({wb_adr_i[7:2], 2'b00})
            tvu_pkg::REG_VSEG:
               state_next.vseg = (state_reg.vseg & ~wm[tvu_pkg::SEG_W-1:0])
                               | (wb_dat_i[tvu_pkg::SEG_W-1:0] & wm[tvu_pkg::SEG_W-1:0]);
            tvu_pkg::REG_CFG:
               state_next.vsc = (state_reg.vsc & ~wm[tvu_pkg::VSC_LSB +: tvu_pkg::VSC_W])
                  | (wb_dat_i[tvu_pkg::VSC_LSB +: tvu_pkg::VSC_W]
                     & wm[tvu_pkg::VSC_LSB +: tvu_pkg::VSC_W]);
            tvu_pkg::REG_TFLAG:
               state_next.tflag = state_reg.tflag
                                & ~(wb_dat_i[tvu_pkg::HW_NUM-1:0] & wm[tvu_pkg::HW_NUM-1:0]);
            tvu_pkg::REG_NODE:
               nset = wb_dat_i & wm;                                       // RULE12
            tvu_pkg::REG_IMASK:
               state_next.imask = (state_reg.imask & ~wm[tvu_pkg::IST_W-1:0])
                                | (wb_dat_i[tvu_pkg::IST_W-1:0] & wm[tvu_pkg::IST_W-1:0]);
            default:
            begin
            end
         endcase
      end

      // Only the bits that were actually returned are cleared by the read.
      if (acc && !wb_we_i && ({wb_adr_i[7:2], 2'b00} == tvu_pkg::REG_IST))
      begin
         state_next.ists = state_reg.ists & ~state_reg.dat[tvu_pkg::IST_W-1:0];
      end

      state_next.tflag = state_next.tflag | hw_cond_i;                     // RULE6

      if (trap_return_i)
      begin
         state_next.busy  = 1'b0;
         state_next.cprio = '0;
      end

      // -------------------------------------------------------------
      // Branch arbitration: reset, hardware, software, node.
      // -------------------------------------------------------------
      hw_ok = sel_bus.valid && (!state_reg.busy || (sel_bus.prio < state_reg.cprio)); // RULE7
      state_next.bv = 1'b0;
      if (!state_reg.rst_done)
      begin
         state_next.rst_done = 1'b1;                                       // RULE13
         state_next.bv       = 1'b1;
         state_next.bkind    = tvu_pkg::KIND_RESET;
         tnum                = tvu_pkg::TRAP_RESET;
         state_next.bprio    = '0;
      end
      else if (hw_ok)
      begin
         state_next.bv    = 1'b1;                                          // RULE5
         state_next.bkind = tvu_pkg::KIND_HW;
         tnum             = sel_bus.trap;
         state_next.bprio = sel_bus.prio;
         state_next.busy  = 1'b1;
         state_next.cprio = sel_bus.prio;
         state_next.ists[tvu_pkg::IST_HW] = 1'b1;
         if (sel_bus.trap == tvu_pkg::TRAP_CLASS_B)
         begin
            hclr[tvu_pkg::HW_NUM-1:tvu_pkg::CLASS_A_NUM] = '1;           // RULE10
         end
         else
         begin
            hclr = sel_bus.pend & ~(sel_bus.pend - 1'b1);
         end
      end
      else if (state_reg.swp)
      begin
         state_next.bv    = 1'b1;
         state_next.bkind = tvu_pkg::KIND_SW;
         tnum             = state_reg.swnum;                               // RULE11
         state_next.bprio = cpu_prio_i;                                    // RULE11
         state_next.swp   = 1'b0;
         state_next.ists[tvu_pkg::IST_SW] = 1'b1;
      end
      else if ((|state_reg.npend) && cpu_int_ready_i && !state_reg.busy) // RULE8
      begin
         state_next.bv    = 1'b1;
         state_next.bkind = tvu_pkg::KIND_NODE;
         tnum             = tvu_pkg::NODE_BASE + tvu_pkg::TRAP_W'(nidx);   // RULE3
         state_next.bprio = cpu_prio_i;
         nclr[nidx]       = 1'b1;
         state_next.ists[tvu_pkg::IST_NODE] = 1'b1;
      end

      if (state_next.bv)
      begin
         state_next.class_b_vector = tnum;
         state_next.last  = tnum;
         state_next.baddr = {state_reg.vseg,                               // RULE1
                             tvu_pkg::vec_offset(tnum, state_reg.vsc)};    // RULE2
      end

      // A new node or software request in the cycle its pending bit is taken is kept; a hardware one is cleared with it.
      state_next.hpend = (state_reg.hpend | hw_cond_i) & ~hclr;
      state_next.npend = (state_reg.npend & ~nclr) | node_req | nset;
      if (sw_trap_i)
      begin
         state_next.swp   = 1'b1;
         state_next.swnum = sw_trap_num_i;
      end
      state_next.ectl = !state_next.busy;                                  // RULE8
      state_next.irq  = |(state_next.ists & state_next.imask);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wb_ack_o            = state_reg.ack;
   assign wb_dat_o            = state_reg.dat;
   assign irq_o               = state_reg.irq;
   assign branch_valid_o      = state_reg.bv;
   assign branch_addr_o       = state_reg.baddr;
   assign branch_trap_o       = state_reg.class_b_vector;
   assign branch_prio_o       = state_reg.bprio;
   assign branch_kind_o       = state_reg.bkind;
   assign event_ctrl_enable_o = state_reg.ectl;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   reset_vector_a: assert property ($fell(rst_i) |=> branch_valid_o              // RULE13
      && branch_kind_o == tvu_pkg::KIND_RESET && branch_addr_o[15:0] == '0
      && branch_prio_o == '0)
      else $error("reset vector not taken first");

   vector_seg_a: assert property (branch_valid_o                                 // RULE1
      |-> branch_addr_o[23:16] == $past(state_reg.vseg))
      else $error("vector outside selected segment");

   vector_space_a: assert property (branch_valid_o                               // RULE2
      |-> branch_addr_o[15:0] == tvu_pkg::vec_offset(branch_trap_o, $past(state_reg.vsc)))
      else $error("vector spacing wrong");

   hw_entry_a: assert property ((!state_reg.busy && hw_cond_i != '0           // RULE5
      && state_reg.rst_done) |=> branch_valid_o && branch_kind_o == tvu_pkg::KIND_HW)
      else $error("hardware trap not taken at once");

   flag_set_a: assert property ((hw_cond_i != '0)                               // RULE6
      |=> (state_reg.tflag & $past(hw_cond_i)) == $past(hw_cond_i))
      else $error("trap flag not set");

   no_preempt_a: assert property ((state_reg.busy && sel_bus.valid             // RULE7
      && sel_bus.prio >= state_reg.cprio)
      |=> !(branch_valid_o && branch_kind_o == tvu_pkg::KIND_HW))
      else $error("trap preempted by equal or lower priority");

   node_hold_a: assert property (state_reg.busy                                 // RULE8
      |=> !(branch_valid_o && branch_kind_o == tvu_pkg::KIND_NODE) && !event_ctrl_enable_o
          || !state_reg.busy)
      else $error("interrupt taken during trap service");

   class_prio_a: assert property ((branch_valid_o && branch_kind_o == tvu_pkg::KIND_HW) // RULE9
      |-> branch_prio_o == branch_trap_o[tvu_pkg::PRIO_W-1:0]
          && (branch_trap_o == tvu_pkg::TRAP_CLASS_B || branch_trap_o[0] == 1'b0))
      else $error("hardware trap priority mismatch");

   class_b_a: assert property ((!state_reg.busy && state_reg.rst_done           // RULE10
      && hw_cond_i[tvu_pkg::CLASS_A_NUM +: 5] != '0
      && hw_cond_i[tvu_pkg::CLASS_A_NUM-1:0] == '0 && state_reg.hpend == '0)
      |=> branch_trap_o == tvu_pkg::TRAP_CLASS_B ##1 state_reg.hpend == '0)
      else $error("class B not on shared vector");

   sw_prio_a: assert property ((branch_valid_o && branch_kind_o == tvu_pkg::KIND_SW) // RULE11
      |-> branch_prio_o == $past(cpu_prio_i))
      else $error("software trap changed priority");

   node_range_a: assert property ((branch_valid_o && branch_kind_o == tvu_pkg::KIND_NODE) // RULE3
      |-> branch_trap_o >= tvu_pkg::NODE_BASE && branch_trap_o <= tvu_pkg::TRAP_SUBCH)
      else $error("node trap number out of range");

   reset_cov_c: cover property ($fell(rst_i) ##1 branch_valid_o);
   class_b_cov_c: cover property (branch_valid_o && branch_trap_o == tvu_pkg::TRAP_CLASS_B);
   sw_cov_c: cover property (branch_valid_o && branch_kind_o == tvu_pkg::KIND_SW);
   node_cov_c: cover property (branch_valid_o && branch_kind_o == tvu_pkg::KIND_NODE);

endmodule

// ==== tb/tvu_cpu_model.sv ====
`timescale 1ns/1ps
module tvu_cpu_model
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       branch_valid_i,
   input  wire logic [1:0] branch_kind_i,
   input  wire logic [7:0] hold_i,
   output logic            trap_return_o,
   output logic            int_ready_o
);
   logic [7:0] left_reg;
   logic [1:0] beat_reg;

   // ----------------------------------------------------------------
   // Trap service timing
   // ----------------------------------------------------------------
   // A preempting trap restarts the count, because one return ends all service.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         left_reg      <= 8'h00;
         beat_reg      <= 2'h0;
         trap_return_o <= 1'b0;
      end
      else
      begin
         beat_reg      <= beat_reg + 2'h1;
         trap_return_o <= (left_reg == 8'h01);
         if (branch_valid_i && branch_kind_i == 2'h1)
            left_reg <= hold_i;
         else if (left_reg != 8'h00)
            left_reg <= left_reg - 8'h01;
      end
   end

   // The core is busy elsewhere one cycle in four, so node entries may stall.
   assign int_ready_o = (beat_reg != 2'h3);
endmodule

// ==== tb/test_trap_and_vector_unit.sv ====
`timescale 1ns/1ps
module test_trap_and_vector_unit;
   logic        clk_i    = 1'b0;
   logic        rst_i    = 1'b1;
   logic        cyc      = 1'b0;
   logic        we       = 1'b0;
   logic [7:0]  adr      = 8'h00;
   logic [31:0] wdat     = 32'h0;
   logic [8:0]  hw       = 9'h000;
   logic        swt      = 1'b0;
   logic [6:0]  swn      = 7'h00;
   logic [3:0]  prio     = 4'h0;
   logic [31:0] nreq     = 32'h0;
   logic [7:0]  hold     = 8'h02;
   logic [7:0]  seg      = 8'h00;
   logic [1:0]  vsc      = 2'h0;
   logic [31:0] rnd      = 32'h000141a1;
   logic [31:0] rdat;
   logic        ack, irq, bv, ece, tret, rdy;
   logic [23:0] baddr;
   logic [6:0]  class_b_vector;
   logic [3:0]  bprio;
   logic [1:0]  bkind;
   logic [36:0] brq[$];
   logic [31:0] rdq[$];
   int          fails    = 0;
   int          compares = 0;

   tvu_trap_vector dut
   (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_o(irq), .hw_cond_i(hw), .sw_trap_i(swt), .sw_trap_num_i(swn), .cpu_prio_i(prio),
      .cpu_int_ready_i(rdy), .trap_return_i(tret), .serial_req_i(nreq[17:0]),
      .scu_req_i({nreq[27], nreq[28]}), .flash_req_i(nreq[29]), .rtc_req_i(nreq[30]),
      .subch_end_req_i(nreq[31]), .branch_valid_o(bv), .branch_addr_o(baddr),
      .branch_trap_o(class_b_vector), .branch_prio_o(bprio), .branch_kind_o(bkind),
      .event_ctrl_enable_o(ece)
   );

   tvu_cpu_model cpu
   (
      .clk_i(clk_i), .rst_i(rst_i), .branch_valid_i(bv), .branch_kind_i(bkind),
      .hold_i(hold), .trap_return_o(tret), .int_ready_o(rdy)
   );

   // ----------------------------------------------------------------
   // Checking
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic void eb(input logic [6:0] t, input logic [3:0] p, input logic [1:0] k);
      brq.push_back({seg, 16'(t) << (2 + vsc), t, p, k});
   endfunction

   task automatic chk_br(input logic [36:0] e, input logic [36:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected branch at %0t: exp %h got %h", $time, e, g);
      end
   endtask

   task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected value at %0t: exp %h got %h", $time, e, g);
      end
   endtask

   task automatic tally_and_finish();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk_i)
   begin
      if (bv === 1'b1)
         chk_br(brq.size() > 0 ? brq.pop_front() : 'x, {baddr, class_b_vector, bprio, bkind});
      if (ack === 1'b1 && we === 1'b0)
         chk_val(rdq.size() > 0 ? rdq.pop_front() : 'x, rdat);
   end

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_i);
      cyc  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do
         @(posedge clk_i);
      while (ack !== 1'b1 && ++n < 50);
      if (n >= 50)
         fails++;
      cyc <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rdq.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask

   task automatic trap(input int k);
      @(posedge clk_i);
      hw <= 9'h001 << k;
      @(posedge clk_i);
      hw <= 9'h000;
   endtask

   task automatic wait_ret();
      int n = 0;
      while (tret !== 1'b1 && n++ < 60)
         @(posedge clk_i);
      if (tret !== 1'b1)
         fails++;
   endtask

   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end

   initial
   begin
      repeat (5000) @(posedge clk_i);
      fails++;
      tally_and_finish();
   end

   initial
   begin
      logic [6:0] t;
      eb(7'h00, 4'h0, 2'h0);
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int a = 0; a < 32; a += 4)
         rd(8'(a), 32'h0);
      rnd = lfsr(rnd);
      seg = rnd[7:0];
      wb(1'b1, 8'h00, 32'(seg));
      for (int k = 0; k < 9; k++)
      begin
         t = (k < 4) ? 7'(2 * k + 2) : 7'h0a;
         eb(t, t[3:0], 2'h1);
         trap(k);
         wait_ret();
         rd(8'h08, 32'h1 << k);
         wb(1'b1, 8'h08, 32'h1ff);
      end
      rd(8'h00, 32'(seg));
      rd(8'h10, 32'h00000a00);
      chk_val(32'(irq), 32'h0);
      wb(1'b1, 8'h18, 32'h1);
      repeat (2) @(posedge clk_i);
      chk_val(32'(irq), 32'h1);
      rd(8'h14, 32'h1);
      rd(8'h14, 32'h0);
      chk_val(32'(irq), 32'h0);
      chk_val(32'(ece), 32'h1);
      for (int v = 0; v < 4; v++)
      begin
         vsc = 2'(v);
         wb(1'b1, 8'h04, 32'(v));
         rnd = lfsr(rnd);
         t = (v == 0) ? 7'h7f : rnd[6:0];
         @(posedge clk_i);
         prio <= rnd[11:8];
         swt  <= 1'b1;
         swn  <= t;
         @(posedge clk_i);
         eb(t, prio, 2'h2);
         swt <= 1'b0;
         repeat (3) @(posedge clk_i);
      end
      rd(8'h04, 32'h3);
      for (int i = 0; i < 32; i++)
      begin
         eb(7'h50 + 7'(i), prio, 2'h3);
         if (i > 17 && i < 27)
            wb(1'b1, 8'h0c, 32'h1 << i);
         else
            trap(-1);
         nreq <= (i > 17 && i < 27) ? 32'h0 : 32'h1 << i;
         @(posedge clk_i);
         nreq <= 32'h0;
         repeat (6) @(posedge clk_i);
      end
      hold <= 8'h14;
      eb(7'h0a, 4'ha, 2'h1);
      trap(4);
      eb(7'h04, 4'h4, 2'h1);
      trap(1);
      trap(5);
      nreq <= 32'h1;
      @(posedge clk_i);
      nreq <= 32'h0;
      @(posedge clk_i);
      chk_val(32'(ece), 32'h0);
      wait_ret();
      eb(7'h0a, 4'ha, 2'h1);
      @(posedge clk_i);
      wait_ret();
      eb(7'h50, prio, 2'h3);
      repeat (12) @(posedge clk_i);
      chk_val(32'(brq.size() + rdq.size()), 32'h0);
      tally_and_finish();
   end
endmodule
